// File: core/push_torque_zone_pause_homing.sv
// motion sequencer: push and hold, torque check, pause, zones, homing
// How it works
// R1: push zero means plain positioning to target
// R2: push mode continues at push speed for band
// R3: position complete once push action judged done
// R4: band run out without push: no complete
// R5: push speed from parameter, capped 10 mm/s
// R6: check band mode: load needs threshold inside band
// R7: check band comes from entry zone fields
// R8: no check band: load on threshold before band end
// R9: no check band: load drops below threshold
// R10: threshold from entry, limited to push range
// R11: contact before target raises servo alarm
// R12: after push, hold force at entry limit
// R13: speed changes only at set change position
// R14: entry acceleration and deceleration applied separately
// R15: pause input active low, low means pause
// R16: pause decelerates to stop, release resumes move; only ST_MOVE obeys it, push run and homing ignore pause
// R17: pause deceleration uses current entry value
// R18: zone output on inside window; code turns it on only once homed
// R19: parameter window from upper and lower params
// R20: table window from entry zone fields
// R21: home return required before normal moves
// R22: pattern not 5: home input rehomes in every state except alarm
// R23: pattern 5: rear move unhomed homes first
// R24: zone output off outside its window
`timescale 1ns/1ps
module push_torque_zone_pause_homing
	import motion_pkg::*;
	#(parameter int TBL_AW = SEL_W)
	(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// controller pins
	input wire logic start_i,
	input wire logic [TBL_AW-1:0] pos_sel_i,
	input wire logic home_req_i,
	input wire logic rear_move_i,
	input wire logic pause_hold_n_i,
	input wire logic alarm_reset_i,
	input wire logic home_sensor_i,
	// drive feedback
	input wire logic [PCT_W-1:0] torque_cmd_i,
	// parameters
	input wire logic [PAT_W-1:0] io_pattern_i,
	input wire logic [VEL_W-1:0] push_speed_i,
	input wire logic [VEL_W-1:0] home_speed_i,
	input wire logic torque_range_i,
	input wire logic [POS_W-1:0] zone_upper_i,
	input wire logic [POS_W-1:0] zone_lower_i,
	input wire logic [JDG_W-1:0] judge_time_i,
	// position table write
	input wire logic tbl_we_i,
	input wire logic [TBL_AW-1:0] tbl_addr_i,
	input wire logic [ENT_W-1:0] tbl_data_i,
	// status outputs
	output logic pos_complete_o,
	output logic load_out_o,
	output logic servo_alarm_o,
	output logic homing_done_o,
	output logic param_window_out_o,
	output logic table_window_out_o,
	output logic servo_on_o,
	output logic paused_o,
	output logic [PCT_W-1:0] current_limit_o,
	output logic [POS_W-1:0] position_o,
	output logic [VEL_W-1:0] velocity_o
	);

	////////////////////////////////////////////////////////////////////
	localparam int SW = TBL_AW + 6;

	logic [SW-1:0] pins_s;
	logic [3:0] prev_reg;
	logic start_s, home_s, rear_s, pause_n_s, arst_s, hsens_s;
	logic [TBL_AW-1:0] sel_s;
	logic start_rise, home_rise, rear_rise, arst_rise;

	pin_sync #(.W(SW)) u_sync (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.pin_i({start_i, pos_sel_i, home_req_i, rear_move_i,
			pause_hold_n_i, alarm_reset_i, home_sensor_i}),
		.sync_o(pins_s)
	);

	assign {start_s, sel_s, home_s, rear_s, pause_n_s, arst_s, hsens_s} =
		pins_s;

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			prev_reg <= 4'h0;
		else
			prev_reg <= {start_s, home_s, rear_s, arst_s};
	end

	assign start_rise = start_s && !prev_reg[3];
	assign home_rise = home_s && !prev_reg[2];
	assign rear_rise = rear_s && !prev_reg[1];
	assign arst_rise = arst_s && !prev_reg[0];

	////////////////////////////////////////////////////////////////////
	logic [TICK_W-1:0] tick_reg;
	logic tick;

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			tick_reg <= '0;
		else if (tick_reg == TICK_LAST)
			tick_reg <= '0;
		else
			tick_reg <= tick_reg + 1'b1;
	end

	assign tick = (tick_reg == TICK_LAST);

	////////////////////////////////////////////////////////////////////
	state_t state_reg;
	logic signed [PW-1:0] pos_reg, tgt_reg;
	logic [VEL_W-1:0] vel_reg;
	logic dir_reg, homed_reg, rear_pend_reg;
	logic [TBL_AW-1:0] rd_addr_reg, rd_addr_next;
	logic [ENT_W-1:0] ent;
	logic [JDG_W-1:0] jcnt_reg;

	pos_table_mem #(.AW(TBL_AW), .DW(ENT_W)) u_table (
		.sys_clk_i(sys_clk_i),
		.we_i(tbl_we_i),
		.waddr_i(tbl_addr_i),
		.wdata_i(tbl_data_i),
		.raddr_i(rd_addr_next),
		.rdata_o(ent)
	);

	logic signed [POS_W-1:0] e_cpos, e_zp, e_zm, pos_um;
	logic signed [PW-1:0] e_tgt_f, e_band_f;
	logic [VEL_W-1:0] e_spd, e_cspd;
	logic [ACC_W-1:0] e_acc, e_dec;
	logic [PCT_W-1:0] e_push, e_thr, thr_lim;

	assign e_tgt_f = $signed({ent[F_TGT +: POS_W], {FRC_W{1'b0}}});
	assign e_band_f = $signed({ent[F_BAND +: POS_W], {FRC_W{1'b0}}});
	assign e_spd = ent[F_SPD +: VEL_W];
	assign e_cpos = $signed(ent[F_CPOS +: POS_W]);
	assign e_cspd = ent[F_CSPD +: VEL_W];
	assign e_acc = ent[F_ACC +: ACC_W];
	assign e_dec = ent[F_DEC +: ACC_W];
	assign e_zp = $signed(ent[F_ZP +: POS_W]);
	assign e_zm = $signed(ent[F_ZM +: POS_W]);
	assign e_push = ent[F_PUSH +: PCT_W];
	assign e_thr = ent[F_THR +: PCT_W];
	assign pos_um = pos_reg[PW-1:FRC_W];

	// threshold outside the push force range is pulled to its edge
	assign thr_lim = (e_thr < PUSH_PCT_MIN) ? PUSH_PCT_MIN :
		(e_thr > PUSH_PCT_MAX) ? PUSH_PCT_MAX : e_thr; // [R10]

	////////////////////////////////////////////////////////////////////
	logic pat5, ready_st, start_go, rear_go, home_go, go_cmd, home_fin;
	logic touch, early_touch, judge_done, over_thr;

	assign pat5 = (io_pattern_i == PAT_NO_HOME_INPUT);
	assign ready_st = (state_reg == ST_IDLE) || (state_reg == ST_HOLD);
	// moves are refused until a home position exists
	assign start_go = start_rise && homed_reg && ready_st; // [R21]
	assign rear_go = rear_rise && pat5 && homed_reg && ready_st;
	assign home_go = (state_reg != ST_ALARM) &&
		((home_rise && !pat5) || // [R22]
		(rear_rise && pat5 && !homed_reg && ready_st)); // [R23]
	assign go_cmd = start_go || rear_go;
	assign home_fin = (state_reg == ST_HOME) && hsens_s;

	always_comb
	begin
		rd_addr_next = rd_addr_reg;
		if (start_go)
			rd_addr_next = sel_s;
		else if (rear_go || (home_fin && rear_pend_reg))
			rd_addr_next = REAR_ENTRY;
	end

	assign touch = (e_push != PUSH_PLAIN) && (torque_cmd_i >= e_push);
	assign early_touch = (state_reg == ST_MOVE) && touch; // [R11]
	assign judge_done = (state_reg == ST_PUSH) && tick && touch &&
		(jcnt_reg >= judge_time_i); // [R3]
	assign over_thr = (torque_cmd_i >= thr_lim);

	////////////////////////////////////////////////////////////////////
	logic signed [PW:0] rem;
	logic [63:0] brake_lhs, brake_rhs;
	logic arrived, brake, passed;
	logic [VEL_W-1:0] cruise, vel_ramp, push_vel;
	logic signed [PW-1:0] vel_ext, pos_step;

	assign rem = dir_reg ?
		$signed({tgt_reg[PW-1], tgt_reg} - {pos_reg[PW-1], pos_reg}) :
		$signed({pos_reg[PW-1], pos_reg} - {tgt_reg[PW-1], tgt_reg});
	assign vel_ext = $signed({{(PW-VEL_W){1'b0}}, vel_reg});
	assign arrived = (rem <= $signed({1'b0, vel_ext}));
	assign pos_step = dir_reg ? pos_reg + vel_ext : pos_reg - vel_ext;

	// stop distance v*v/(2*dec) compared without a divider
	assign brake_lhs = 64'(e_dec) * 64'(rem[PW-1:0]) * 64'h2;
	assign brake_rhs = 64'(vel_reg) * 64'(vel_reg);
	assign brake = !rem[PW] && (brake_lhs <= brake_rhs); // [R14]

	assign passed = dir_reg ? (pos_um >= e_cpos) : (pos_um <= e_cpos);
	// a zero change position means no change point is set
	assign cruise = ((e_cpos != '0) && passed) ? e_cspd : e_spd; // [R13]
	assign push_vel = (push_speed_i > PUSH_VEL_MAX) ? PUSH_VEL_MAX :
		push_speed_i; // [R5]

	always_comb
	begin
		vel_ramp = vel_reg;
		if (!pause_n_s || brake || (vel_reg > cruise))
		begin
			// pause and braking ramp down on the entry deceleration
			if (vel_reg > VEL_W'(e_dec))
				vel_ramp = vel_reg - VEL_W'(e_dec); // [R16] [R17]
			else
				vel_ramp = '0;
			if (pause_n_s && !brake && (vel_ramp < cruise))
				vel_ramp = cruise;
		end
		else if (vel_reg < cruise)
		begin
			if (cruise - vel_reg > VEL_W'(e_acc))
				vel_ramp = vel_reg + VEL_W'(e_acc); // [R14]
			else
				vel_ramp = cruise;
		end
	end

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_reg <= ST_IDLE;
			pos_reg <= '0;
			tgt_reg <= '0;
			vel_reg <= '0;
			dir_reg <= 1'b0;
		end
		else if (home_go)
		begin
			state_reg <= ST_HOME;
			vel_reg <= home_speed_i;
			dir_reg <= 1'b0;
		end
		else if (go_cmd)
			state_reg <= ST_LOAD;
		else
		begin
			case (state_reg)
			ST_ALARM:
				if (arst_rise)
					state_reg <= ST_IDLE;
			ST_LOAD:
			begin
				tgt_reg <= e_tgt_f;
				dir_reg <= (e_tgt_f > pos_reg);
				vel_reg <= '0;
				state_reg <= ST_MOVE;
			end
			ST_MOVE:
				if (early_touch)
				begin
					state_reg <= ST_ALARM;
					vel_reg <= '0;
				end
				else if (tick && arrived)
				begin
					pos_reg <= tgt_reg;
					if (e_push == PUSH_PLAIN)
					begin
						state_reg <= ST_IDLE; // [R1]
						vel_reg <= '0;
					end
					else
					begin
						// push run: band length beyond target, sign picks way
						state_reg <= ST_PUSH; // [R2]
						vel_reg <= push_vel; // [R5]
						tgt_reg <= tgt_reg + e_band_f;
						dir_reg <= !e_band_f[PW-1];
					end
				end
				else if (tick)
				begin
					pos_reg <= pos_step;
					vel_reg <= vel_ramp;
				end
			ST_PUSH:
				if (judge_done)
				begin
					state_reg <= ST_HOLD; // [R3]
					vel_reg <= '0;
				end
				else if (tick && arrived)
				begin
					pos_reg <= tgt_reg;
					state_reg <= ST_IDLE; // [R4]
					vel_reg <= '0;
				end
				else if (tick)
					pos_reg <= pos_step;
			ST_HOME:
				if (hsens_s)
				begin
					pos_reg <= '0;
					vel_reg <= '0;
					state_reg <= rear_pend_reg ? ST_LOAD : ST_IDLE; // [R23]
				end
				else if (tick)
					pos_reg <= pos_step;
			default:
				;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			homed_reg <= 1'b0;
			rear_pend_reg <= 1'b0;
			rd_addr_reg <= '0;
		end
		else
		begin
			rd_addr_reg <= rd_addr_next;
			if (home_go)
			begin
				homed_reg <= 1'b0; // [R22]
				rear_pend_reg <= pat5;
			end
			else if (home_fin)
			begin
				homed_reg <= 1'b1; // [R21]
				rear_pend_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			jcnt_reg <= '0;
		else if (state_reg != ST_PUSH)
			jcnt_reg <= '0;
		else if (tick)
			jcnt_reg <= touch ? jcnt_reg + 1'b1 : '0;
	end

	////////////////////////////////////////////////////////////////////
	logic in_check;
	logic [1:0] win_in;
	logic signed [POS_W-1:0] win_up [0:1];
	logic signed [POS_W-1:0] win_lo [0:1];

	// equal bounds disable a window; upper below lower wraps round
	function automatic logic in_window(input logic signed [POS_W-1:0] p,
		input logic signed [POS_W-1:0] up, input logic signed [POS_W-1:0] lo);
		if (up == lo)
			in_window = 1'b0;
		else if (up > lo)
			in_window = (p >= lo) && (p <= up);
		else
			in_window = (p >= lo) || (p <= up);
	endfunction

	assign win_up[0] = $signed(zone_upper_i); // [R19]
	assign win_lo[0] = $signed(zone_lower_i);
	assign win_up[1] = e_zp; // [R20]
	assign win_lo[1] = e_zm;
	assign in_check = in_window(pos_um, e_zp, e_zm); // [R7]

	generate
		for (genvar i = 0; i < 2; i++)
		begin : g_win
			assign win_in[i] = homed_reg &&
				in_window(pos_um, win_up[i], win_lo[i]);
		end
	endgenerate

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			param_window_out_o <= 1'b0;
			table_window_out_o <= 1'b0;
		end
		else
		begin
			param_window_out_o <= win_in[0]; // [R18] [R24]
			table_window_out_o <= win_in[1]; // [R18] [R24]
		end
	end

	////////////////////////////////////////////////////////////////////
	logic pushing;

	assign pushing = (state_reg == ST_PUSH) || (state_reg == ST_HOLD);

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pos_complete_o <= 1'b0;
		else if (go_cmd || home_go || (state_reg == ST_ALARM))
			pos_complete_o <= 1'b0;
		else if ((state_reg == ST_MOVE) && tick && arrived &&
			(e_push == PUSH_PLAIN) && !early_touch)
			pos_complete_o <= 1'b1; // [R1]
		else if (judge_done)
			pos_complete_o <= 1'b1; // [R3]
		else if (state_reg == ST_HOLD)
			pos_complete_o <= touch;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			load_out_o <= 1'b0;
		else if (go_cmd || home_go)
			load_out_o <= 1'b0;
		else if (pushing && (torque_range_i == TCHK_NONE))
			load_out_o <= over_thr; // [R8] [R9]
		else if (pushing && over_thr && in_check)
			load_out_o <= 1'b1; // [R6]
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			servo_alarm_o <= 1'b0;
			servo_on_o <= 1'b0;
			current_limit_o <= CUR_LIMIT_FULL;
			homing_done_o <= 1'b0;
			paused_o <= 1'b0;
		end
		else
		begin
			servo_alarm_o <= early_touch ||
				((state_reg == ST_ALARM) && !arst_rise); // [R11]
			servo_on_o <= (state_reg != ST_ALARM); // [R12]
			current_limit_o <= pushing ? e_push : CUR_LIMIT_FULL; // [R12]
			homing_done_o <= (homed_reg || home_fin) && !home_go; // [R22]
			paused_o <= !pause_n_s; // [R15]
		end
	end

	assign position_o = pos_um;
	assign velocity_o = vel_reg;

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	plain_finish_a: assert property ((state_reg == ST_MOVE) && tick &&
		arrived && !early_touch && (e_push == PUSH_PLAIN) && !home_go &&
		!go_cmd |=> (state_reg == ST_IDLE) && pos_complete_o) // [R1]
		else $error("plain move did not complete");
	push_enter_a: assert property ((state_reg == ST_MOVE) && tick &&
		arrived && !early_touch && !home_go && !go_cmd |=>
		(state_reg == ST_PUSH) || pos_complete_o) // [R2]
		else $error("push run not entered");
	push_speed_a: assert property ((state_reg == ST_PUSH) |->
		(vel_reg <= PUSH_VEL_MAX)) // [R5]
		else $error("push speed above ceiling");
	miss_nocomp_a: assert property ((state_reg == ST_PUSH) && tick &&
		arrived && !judge_done && !home_go && !go_cmd |=>
		!pos_complete_o [*2]) // [R4]
		else $error("complete set after missed push");
	early_alarm_a: assert property (early_touch && !home_go && !go_cmd
		|=> servo_alarm_o && (state_reg == ST_ALARM)) // [R11]
		else $error("early contact without alarm");
	hold_force_a: assert property ((state_reg == ST_HOLD) ##1
		(state_reg == ST_HOLD) |-> servo_on_o &&
		(current_limit_o == $past(e_push))) // [R12]
		else $error("hold force not applied");
	load_drop_a: assert property (pushing && !go_cmd && !home_go &&
		(torque_range_i == TCHK_NONE) && !over_thr |=> !load_out_o) // [R9]
		else $error("load output held under threshold");
	pause_hold_a: assert property ((state_reg == ST_MOVE) && !pause_n_s &&
		(vel_reg == '0) && !arrived && !early_touch && !home_go |=>
		(vel_reg == '0)) // [R16]
		else $error("motion while paused");
	zone_off_a: assert property (!win_in[0] ##1 !win_in[0] |->
		!param_window_out_o) // [R24]
		else $error("parameter zone on outside window");
	home_start_a: assert property (home_rise && !pat5 &&
		(state_reg != ST_ALARM) |=> (state_reg == ST_HOME) &&
		!homing_done_o) // [R22]
		else $error("home request ignored");
	rear_home_a: assert property (home_go && pat5 |=> rear_pend_reg &&
		(state_reg == ST_HOME)) // [R23]
		else $error("rear move did not home first");

	push_done_c: cover property ((state_reg == ST_PUSH) ##1
		(state_reg == ST_HOLD) ##1 pos_complete_o);
	pause_resume_c: cover property ((state_reg == ST_MOVE) && !pause_n_s
		##[1:1000] (state_reg == ST_MOVE) && pause_n_s);
	rear_after_home_c: cover property (home_fin && rear_pend_reg
		##1 (state_reg == ST_LOAD));
	load_on_c: cover property (!load_out_o ##1 load_out_o);

endmodule

// File: core/motion_pkg.sv
// shared constants, entry layout and state codes for the positioner logic
package motion_pkg;

	// clock and motion tick
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS = 10000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int TICK_W = 10;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

	// widths: position in um, velocity in 1/4096 um per tick
	localparam int POS_W = 24;
	localparam int FRC_W = 12;
	localparam int PW = POS_W + FRC_W;
	localparam int VEL_W = 20;
	localparam int ACC_W = 16;
	localparam int PCT_W = 8;
	localparam int SEL_W = 6;
	localparam int PAT_W = 3;
	localparam int JDG_W = 16;

	// push speed ceiling, 10 mm/s turned into velocity units
	localparam int PUSH_SPEED_MAX_MM_S = 10;
	localparam int UM_PER_MM = 1000;
	localparam int TICKS_PER_S = 1000000000 / TICK_NS;
	localparam logic [VEL_W-1:0] PUSH_VEL_MAX = VEL_W'(
		PUSH_SPEED_MAX_MM_S * UM_PER_MM * (2 ** FRC_W) / TICKS_PER_S);

	// configuration codes
	localparam logic [PAT_W-1:0] PAT_NO_HOME_INPUT = 3'h5;
	localparam logic TCHK_BAND = 1'h0;
	localparam logic TCHK_NONE = 1'h1;
	localparam logic [PCT_W-1:0] PUSH_PLAIN = 8'h00;
	localparam logic [PCT_W-1:0] PUSH_PCT_MIN = 8'h14;
	localparam logic [PCT_W-1:0] PUSH_PCT_MAX = 8'h46;
	localparam logic [PCT_W-1:0] CUR_LIMIT_FULL = 8'h64;
	localparam logic [SEL_W-1:0] REAR_ENTRY = 6'h00;

	// position entry field offsets
	localparam int F_TGT = 0;
	localparam int F_BAND = 24;
	localparam int F_SPD = 48;
	localparam int F_CPOS = 68;
	localparam int F_CSPD = 92;
	localparam int F_ACC = 112;
	localparam int F_DEC = 128;
	localparam int F_ZP = 144;
	localparam int F_ZM = 168;
	localparam int F_PUSH = 192;
	localparam int F_THR = 200;
	localparam int ENT_W = 208;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_LOAD = 3'h1,
		ST_MOVE = 3'h2,
		ST_PUSH = 3'h3,
		ST_HOLD = 3'h4,
		ST_HOME = 3'h5,
		ST_ALARM = 3'h6
	} state_t;

endpackage

// File: core/pin_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync
	#(parameter int W = 1)
	(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// pins in, synchronised out
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] sync_o
	);

	logic [W-1:0] meta_reg;

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_reg <= '0;
			sync_o <= '0;
		end
		else
		begin
			meta_reg <= pin_i;
			sync_o <= meta_reg;
		end
	end

endmodule

// File: core/pos_table_mem.sv
// position table storage, one write port and a registered read port
`timescale 1ns/1ps
module pos_table_mem
	#(parameter int AW = 6,
	parameter int DW = 208)
	(
	// clock
	input wire logic sys_clk_i,
	// write side
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [DW-1:0] wdata_i,
	// read side
	input wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0] rdata_o
	);

	logic [DW-1:0] mem [0:(2**AW)-1];

	always_ff @(posedge sys_clk_i)
	begin
		if (we_i)
			mem[waddr_i] <= wdata_i;
		rdata_o <= mem[raddr_i];
	end

endmodule

// File: sim/load_model.sv
// far side model: home switch and a work part that pushes back
`timescale 1ns/1ps
module load_model
	import motion_pkg::*;
	(
	// actuator state
	input wire logic [POS_W-1:0] position_i,
	input wire logic [POS_W-1:0] contact_i,
	// sensed back
	output logic home_sensor_o,
	output logic [PCT_W-1:0] torque_cmd_o
	);
	// switch closes at and below zero
	assign home_sensor_o = $signed(position_i) <= 0;
	// torque only climbs once the part is reached; low level otherwise
	assign torque_cmd_o = ($signed(position_i) >= $signed(contact_i))
		? 8'h50 : 8'h05;
endmodule

// File: sim/testbench.sv
// self-checking bench for the motion sequencer
`timescale 1ns/1ps
module testbench;
	import motion_pkg::*;
	logic clk = 0, rst_n = 0, st = 0, hr = 0, rm = 0, ps_n = 1, ar = 0;
	logic [5:0] sel = 0;
	logic [2:0] pat = 0;
	logic t51 = 1, we = 0;
	logic [5:0] wa = 0;
	logic [ENT_W-1:0] wd = '0;
	logic [POS_W-1:0] contact = 24'h0003E8;
	logic hs, pc, lo, sa, hd, pw, tw, so, pz;
	logic [7:0] tq, cl;
	logic [POS_W-1:0] pos, p;
	logic [VEL_W-1:0] vel;
	int num_errors = 0, n_compared = 0;
	initial forever #5 clk = ~clk;
	push_torque_zone_pause_homing i_push_torque_zone_pause_homing (
		.sys_clk_i(clk), .rst_n_i(rst_n), .start_i(st), .pos_sel_i(sel),
		.home_req_i(hr), .rear_move_i(rm), .pause_hold_n_i(ps_n),
		.alarm_reset_i(ar), .home_sensor_i(hs), .torque_cmd_i(tq),
		.io_pattern_i(pat), .push_speed_i(20'hFFFFF),
		.home_speed_i(20'hFFFFF), .torque_range_i(t51),
		.zone_upper_i(24'h00012C), .zone_lower_i(24'h000064),
		.judge_time_i(16'h0002), .tbl_we_i(we), .tbl_addr_i(wa),
		.tbl_data_i(wd), .pos_complete_o(pc), .load_out_o(lo),
		.servo_alarm_o(sa), .homing_done_o(hd), .param_window_out_o(pw),
		.table_window_out_o(tw), .servo_on_o(so), .paused_o(pz),
		.current_limit_o(cl), .position_o(pos), .velocity_o(vel));
	load_model i_load_model (.position_i(pos), .contact_i(contact),
		.home_sensor_o(hs), .torque_cmd_o(tq));
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			num_errors++;
			$display("wrong value at %0t: got %0h want %0h", $time, s, e);
		end
	endtask
	task automatic wrap_up();
		$display("errors %0d, compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	function automatic logic [ENT_W-1:0] ent(input int t, b, pu, th, zp,
		zm);
		logic [ENT_W-1:0] e;
		e = '0;
		e[F_TGT+:POS_W] = POS_W'(t);
		e[F_BAND+:POS_W] = POS_W'(b);
		e[F_SPD+:VEL_W] = 20'h3FFFF;
		e[F_ACC+:ACC_W] = 16'hFFFF;
		e[F_DEC+:ACC_W] = 16'hFFFF;
		e[F_ZP+:POS_W] = POS_W'(zp);
		e[F_ZM+:POS_W] = POS_W'(zm);
		e[F_PUSH+:PCT_W] = PCT_W'(pu);
		e[F_THR+:PCT_W] = PCT_W'(th);
		return e;
	endfunction
	task automatic wr(input int a, input logic [ENT_W-1:0] d);
		@(negedge clk);
		we = 1;
		wa = 6'(a);
		wd = d;
		@(negedge clk);
		we = 0;
	endtask
	// pins held well past the two-flop sync on both levels
	task automatic pulse(input int k);
		@(negedge clk);
		case (k)
			0: st = 1;
			1: hr = 1;
			2: rm = 1;
			default: ar = 1;
		endcase
		repeat (4) @(negedge clk);
		{st, hr, rm, ar} = 4'h0;
		repeat (4) @(negedge clk);
	endtask
	task automatic go(input int s);
		@(negedge clk);
		sel = 6'(s);
		repeat (4) @(negedge clk);
		pulse(0);
	endtask
	// bounded wait: 0 complete, 1 homed, 2 alarm, 3 position p reached
	task automatic wt(input int n, input int w);
		repeat (n)
		begin
			@(negedge clk);
			if ((w == 0 && pc === 1'b1) || (w == 1 && hd === 1'b1)
				|| (w == 2 && sa === 1'b1) || (w == 3 && pos >= p))
				break;
		end
	endtask
	////////////////////////////////////////////////////////////////////
	// push phases must never run faster than the ceiling
	always @(negedge clk)
		if (rst_n && cl !== CUR_LIMIT_FULL && vel > PUSH_VEL_MAX)
			chk(vel, PUSH_VEL_MAX);
	initial
	begin
		repeat (97000) @(posedge clk);
		num_errors++;
		wrap_up();
	end
	initial
	begin
		repeat (6) @(negedge clk);
		rst_n = 1;
		chk(cl, CUR_LIMIT_FULL);
		wr(0, ent(30, 0, 0, 0, 0, 0));
		wr(1, ent(200, 0, 0, 0, 250, 150));
		wr(2, ent(400, 0, 0, 0, 250, 150));
		wr(3, ent(0, 0, 0, 0, 0, 0));
		wr(4, ent(100, 3, 'h32, 'h60, 0, 0));
		wr(5, ent(150, 1, 'h32, 'h28, 0, 0));
		wr(6, ent(160, 3, 'h32, 'h28, 200, 150));
		wr(7, ent(170, 3, 'h32, 'h28, 20, 10));
		wr(8, ent(250, 3, 'h32, 'h28, 0, 0));
		// slow-down point at 60 um, second speed 16 um per tick
		wd = ent(230, 0, 0, 0, 0, 0);
		wd[F_CPOS+:POS_W] = 24'h00003C;
		wd[F_CSPD+:VEL_W] = 20'h10000;
		wr(9, wd);
		go(1);
		repeat (2000) @(negedge clk);
		chk(pos, 0);
		pulse(1);
		wt(5000, 1);
		chk(hd, 1);
		go(1);
		wt(30000, 0);
		chk(pc, 1);
		chk(pos, 200);
		chk(pw, 1);
		chk(tw, 1);
		pulse(1);
		wt(5000, 1);
		chk(hd, 1);
		chk(pos, 0);
		go(2);
		wt(30000, 0);
		chk(pos, 400);
		chk({pw, tw}, 0);
		go(3);
		repeat (3000) @(negedge clk);
		ps_n = 0;
		repeat (5000) @(negedge clk);
		chk({pz, pc}, 2);
		chk(vel, 0);
		p = pos;
		repeat (2000) @(negedge clk);
		chk(pos, p);
		ps_n = 1;
		wt(30000, 0);
		chk(pos, 0);
		contact = 24'h000064;
		go(4);
		wt(40000, 0);
		chk({pc, lo, so}, 7);
		chk(cl, 8'h32);
		contact = 24'h0003E8;
		repeat (5) @(negedge clk);
		chk(lo, 0);
		p = 24'h000097;
		go(5);
		wt(20000, 3);
		repeat (3) @(negedge clk);
		chk(pos, 151);
		chk(pc, 0);
		t51 = 0;
		contact = 24'h0000A0;
		go(6);
		wt(40000, 0);
		chk({pc, lo}, 3);
		contact = 24'h0000AA;
		go(7);
		wt(40000, 0);
		chk({pc, lo}, 2);
		contact = 24'h0000C8;
		go(8);
		wt(30000, 2);
		chk(sa, 1);
		pulse(3);
		chk(sa, 0);
		@(negedge clk);
		rst_n = 0;
		pat = PAT_NO_HOME_INPUT;
		contact = 24'h0003E8;
		repeat (6) @(negedge clk);
		rst_n = 1;
		pulse(2);
		wt(5000, 1);
		chk(hd, 1);
		wt(30000, 0);
		chk(pos, 30);
		p = 24'h000096;
		go(9);
		wt(20000, 3);
		chk(vel, 20'h10000);
		wrap_up();
	end
endmodule
